// ==== hdl/hbfp_top.sv ====
// bridge protection and fault latch logic with avalon register slave
// How it works
// - short circuit latches outputs off, flag low
// - disable edge clears latch, flag released
// - outputs follow inputs outside latched faults
// - current limit forces 20 us off time
// - overtemperature latches outputs off, flag low
// - restart only below threshold minus hysteresis
// - successful reset clears fault flag
// - each direction input sets its output
// - disable inputs tristate both outputs
// - undervoltage off, recovers automatically
// - enable low keeps device asleep
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "hbfp_map.svh"
module hbfp_top #(
	parameter int TOFF_CYC = `HBFP_TOFF_CYC
) (
	// clock and reset
	clk,
	rst_n,
	// host control pins
	dir_in_a,
	dir_in_b,
	disable_hi_active,
	disable_lo_active_n,
	enable,
	// analog comparator pins
	short_detect,
	overtemp_detect,
	overtemp_below_hyst,
	undervolt_detect,
	current_limit_hit,
	// bridge drive
	bridge_out_a,
	bridge_out_a_oe_n,
	bridge_out_b,
	bridge_out_b_oe_n,
	// open drain fault flag
	fault_flag_n_o,
	fault_flag_n_oe_n,
	// avalon slave
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_readdata,
	avs_waitrequest,
	// interrupt
	irq
);
	// clock and reset
	input wire logic clk;
	input wire logic rst_n;
	// host control pins
	input wire logic dir_in_a;
	input wire logic dir_in_b;
	input wire logic disable_hi_active;
	input wire logic disable_lo_active_n;
	input wire logic enable;
	// analog comparator pins
	input wire logic short_detect;
	input wire logic overtemp_detect;
	input wire logic overtemp_below_hyst;
	input wire logic undervolt_detect;
	input wire logic current_limit_hit;
	// bridge drive
	output logic bridge_out_a;
	output logic bridge_out_a_oe_n;
	output logic bridge_out_b;
	output logic bridge_out_b_oe_n;
	// open drain fault flag
	output logic fault_flag_n_o;
	output logic fault_flag_n_oe_n;
	// avalon slave
	input wire logic [3:0] avs_address;
	input wire logic avs_read;
	input wire logic avs_write;
	input wire logic [31:0] avs_writedata;
	output logic [31:0] avs_readdata;
	output logic avs_waitrequest;
	// interrupt
	output logic irq;

	// every pin passes two flip-flops before any logic reads it, so a pin change that reaches the outputs directly
	// shows on the bridge three clock edges later (two sync, one output); through a fault latch or the chop state it takes four
	// the low-active disable is inverted ahead of the sync: its stages then reset
	// to the idle level and no false reset edge appears when reset is released
	logic [9:0] pinRaw; // pins as they arrive
	logic [9:0] pinSync; // pins after two stages
	assign pinRaw = {dir_in_a, dir_in_b, disable_hi_active, ~disable_lo_active_n, enable,
		short_detect, overtemp_detect, overtemp_below_hyst, undervolt_detect, current_limit_hit};

	hbfp_sync #(.W(10)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din(pinRaw),
		.dout(pinSync)
	);

	// named views of the synchronised pins
	wire dirA = pinSync[9];
	wire dirB = pinSync[8];
	wire disHi = pinSync[7];
	wire disLoN = ~pinSync[6]; // undo the inversion made ahead of the sync
	wire enSync = pinSync[5];
	wire shortS = pinSync[4];
	wire otempS = pinSync[3];
	wire coolS = pinSync[2];
	wire uvoltS = pinSync[1];
	wire limS = pinSync[0];

	// previous disable levels for edge detection (reset to idle, not-disabled levels)
	logic disHi_q;
	logic disLoN_q;
	// fault latches
	logic shortLatch_q;
	logic otempLatch_q;
	logic otempWait_q; // reset edge seen, waiting for cooldown
	// chop sequencer
	hbfp_pkg::hbfp_chop_t chopState_q; // idle or inside the off time
	logic [15:0] chopCnt_q;
	// registers
	logic [31:0] ctrl_q;
	logic [`HBFP_EV_W-1:0] irqStat_q;
	logic [`HBFP_EV_W-1:0] irqMask_q;

	// disable edge that resets a latched fault
	wire resetEdge = (disHi_q & ~disHi) | (~disLoN_q & disLoN);
	wire awake = enSync;
	wire disabled = disHi | ~disLoN;
	wire latched = shortLatch_q | otempLatch_q;
	wire chopOff = (chopState_q == hbfp_pkg::CHOP_OFF);
	wire chopEn = ctrl_q[`HBFP_CTRL_CHOP_EN];
	wire startChop = awake & chopEn & limS & ~chopOff & ~latched;
	wire chopDone = chopOff & (chopCnt_q == 16'(TOFF_CYC - 1));
	// outputs enabled only with nothing latched, undervoltage clear, not chopping
	wire driveOn = awake & ~disabled & ~latched & ~uvoltS & ~chopOff;
	wire faultLow = awake & (latched | uvoltS);

	// event pulses for the interrupt status; latch events fire once on entry,
	// undervoltage reports every cycle it lasts, clear fires on a release edge
	// seen while a latch is held
	wire [`HBFP_EV_W-1:0] events;
	assign events[`HBFP_EV_SHORT] = awake & shortS & ~shortLatch_q;
	assign events[`HBFP_EV_OTEMP] = awake & otempS & ~otempLatch_q;
	assign events[`HBFP_EV_UVOLT] = awake & uvoltS;
	assign events[`HBFP_EV_CHOP] = startChop;
	assign events[`HBFP_EV_CLEAR] = awake & resetEdge & latched;

	// register decode
	wire selCtrl = avs_address == `HBFP_REG_CTRL;
	wire selStat = avs_address == `HBFP_REG_STAT;
	wire selIrq = avs_address == `HBFP_REG_IRQ;
	wire selMask = avs_address == `HBFP_REG_MASK;
	// request seen while waitrequest is still high: read data is loaded here
	wire acc = (avs_read | avs_write) & avs_waitrequest;
	// completion edge, waitrequest low: writes take effect here and nowhere else
	wire done = (avs_read | avs_write) & ~avs_waitrequest;
	wire wrCtrl = done & avs_write & selCtrl;
	wire wrIrq = done & avs_write & selIrq;
	wire wrMask = done & avs_write & selMask;
	// status: b5 asleep, b4 driven, b3 chopping, b2 undervolt, b1 otemp, b0 short
	wire [31:0] statWord = {26'h0, ~awake, driveOn, chopOff, uvoltS, otempLatch_q, shortLatch_q};
	wire [31:0] rdMux = selCtrl ? ctrl_q :
		selStat ? statWord :
		selIrq ? {27'h0, irqStat_q} :
		selMask ? {27'h0, irqMask_q} : 32'h0;

	// disable edge history; it tracks the pins even while asleep, so waking
	// with a disable pin already moved does not count as a reset edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			disHi_q <= 1'b0;
			disLoN_q <= 1'b1;
		end else begin
			disHi_q <= disHi;
			disLoN_q <= disLoN;
		end
	end

	// short circuit latch: set wins over a coincident reset edge; a short still
	// present holds the latch, so a disable toggle made too early is ignored
	// and the host has to repeat it once the short is gone
	always_ff @(posedge clk) begin
		if (!rst_n || !awake) begin
			shortLatch_q <= 1'b0;
		end else if (shortS) begin
			shortLatch_q <= 1'b1;
		end else if (resetEdge) begin
			shortLatch_q <= 1'b0;
		end
	end

	// overtemperature latch with hysteresis qualified release; a reset edge
	// that comes while still hot is remembered until the die has cooled
	always_ff @(posedge clk) begin
		if (!rst_n || !awake) begin
			otempLatch_q <= 1'b0;
			otempWait_q <= 1'b0;
		end else if (otempS) begin
			otempLatch_q <= 1'b1;
			otempWait_q <= otempWait_q | (resetEdge & otempLatch_q);
		end else if (otempLatch_q && (resetEdge || otempWait_q)) begin
			// release only once cooled below threshold minus hysteresis
			otempLatch_q <= ~coolS;
			otempWait_q <= ~coolS;
		end
	end

	// fixed off time current limit chop
	// the off time lasts TOFF_CYC clocks, counted from zero; a limit still
	// present when it ends starts the next off time one clock later, after one idle cycle
	always_ff @(posedge clk) begin
		if (!rst_n || !awake || latched) begin
			chopState_q <= hbfp_pkg::CHOP_IDLE;
			chopCnt_q <= 16'h0;
		end else begin
			case (chopState_q)
				hbfp_pkg::CHOP_IDLE: begin
					if (startChop) begin
						chopState_q <= hbfp_pkg::CHOP_OFF;
					end
					chopCnt_q <= 16'h0;
				end
				hbfp_pkg::CHOP_OFF: begin
					if (chopDone) begin
						chopState_q <= hbfp_pkg::CHOP_IDLE;
						chopCnt_q <= 16'h0;
					end else begin
						chopCnt_q <= chopCnt_q + 16'h1;
					end
				end
				default: begin
					chopState_q <= hbfp_pkg::CHOP_IDLE;
				end
			endcase
		end
	end

	// bridge and flag pins, registered
	// the data pins follow the direction inputs at all times; only the
	// enables decide whether the bridge really drives
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bridge_out_a <= 1'b0;
			bridge_out_b <= 1'b0;
			bridge_out_a_oe_n <= 1'b1;
			bridge_out_b_oe_n <= 1'b1;
			fault_flag_n_o <= 1'b0;
			fault_flag_n_oe_n <= 1'b1;
		end else begin
			bridge_out_a <= dirA;
			bridge_out_b <= dirB;
			bridge_out_a_oe_n <= ~driveOn;
			bridge_out_b_oe_n <= ~driveOn;
			fault_flag_n_o <= 1'b0;
			fault_flag_n_oe_n <= ~faultLow;
		end
	end

	// control and mask registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= `HBFP_CTRL_RESET;
			irqMask_q <= '0;
		end else begin
			if (wrCtrl) begin
				ctrl_q <= {31'h0, avs_writedata[`HBFP_CTRL_CHOP_EN]};
			end
			if (wrMask) begin
				irqMask_q <= avs_writedata[`HBFP_EV_W-1:0];
			end
		end
	end

	// sticky event bits: new events win over write-one-to-clear
	// so an event landing in the clearing cycle is never lost
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irqStat_q <= '0;
		end else begin
			irqStat_q <= (irqStat_q & ~(wrIrq ? avs_writedata[`HBFP_EV_W-1:0] : '0)) | events;
		end
	end

	// bus answer: one wait cycle, then data with waitrequest low
	// waitrequest rests high, drops for the completion cycle of each access
	// and rises again behind it, so every access takes two cycles
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
			irq <= 1'b0;
		end else begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if (acc && avs_read) begin
				avs_readdata <= rdMux;
			end
			irq <= |(irqStat_q & irqMask_q);
		end
	end
endmodule

// ==== hdl/hbfp_map.svh ====
// register offsets, field positions, reset values and timing counts of the bridge protection block
`ifndef HBFP_MAP_SVH
`define HBFP_MAP_SVH
// register word offsets (byte address = 4 * index)
`define HBFP_REG_CTRL 4'h0
`define HBFP_REG_STAT 4'h1
`define HBFP_REG_IRQ 4'h2
`define HBFP_REG_MASK 4'h3
// control register fields
`define HBFP_CTRL_CHOP_EN 0
`define HBFP_CTRL_RESET 32'h0000_0001
// status register fields
`define HBFP_ST_SHORT 0
`define HBFP_ST_OTEMP 1
`define HBFP_ST_UVOLT 2
`define HBFP_ST_CHOP 3
`define HBFP_ST_OUTEN 4
`define HBFP_ST_SLEEP 5
// interrupt event bits
`define HBFP_EV_SHORT 0
`define HBFP_EV_OTEMP 1
`define HBFP_EV_UVOLT 2
`define HBFP_EV_CHOP 3
`define HBFP_EV_CLEAR 4
`define HBFP_EV_W 5
// current limit off time
`define HBFP_TOFF_NS 20000
`define HBFP_CLK_MHZ 25
`define HBFP_TOFF_CYC ((`HBFP_TOFF_NS * `HBFP_CLK_MHZ) / 1000)
`endif

// ==== hdl/hbfp_pkg.sv ====
// types of the bridge protection block
package hbfp_pkg;
	// chop sequencer states
	typedef enum logic [1:0] {
		CHOP_IDLE = 2'b00,
		CHOP_OFF = 2'b01
	} hbfp_chop_t;
endpackage

// ==== hdl/hbfp_sync.sv ====
// two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
module hbfp_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins in and synchronised out
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] stage1_q; // first stage, read only by second

	// both stages clear on reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1_q <= '0;
			dout <= '0;
		end else begin
			stage1_q <= din;
			dout <= stage1_q;
		end
	end
endmodule

// ==== dv/hbfp_top_assertions.sv ====
// port-level checks of the bridge protection block
`timescale 1ns/10ps
module hbfp_top_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// host pins
	input wire logic dir_in_a,
	input wire logic disable_hi_active,
	input wire logic disable_lo_active_n,
	input wire logic enable,
	input wire logic short_detect,
	// bridge, flag and bus
	input wire logic bridge_out_a,
	input wire logic bridge_out_a_oe_n,
	input wire logic bridge_out_b_oe_n,
	input wire logic fault_flag_n_o,
	input wire logic fault_flag_n_oe_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// both half bridges floating
	wire offBoth = bridge_out_a_oe_n && bridge_out_b_oe_n;
	chk_short_latch: assert property (
		$rose(short_detect) && enable |-> ##[1:5] !fault_flag_n_oe_n) else $error("short");
	chk_flag_offs: assert property (
		!fault_flag_n_oe_n |-> offBoth) else $error("flag on");
	chk_flag_data: assert property (
		fault_flag_n_o == 1'b0) else $error("flag data");
	chk_dis_hi: assert property (
		disable_hi_active [*4] |-> offBoth) else $error("dis hi");
	chk_dis_lo: assert property (
		!disable_lo_active_n [*4] |-> offBoth) else $error("dis lo");
	chk_sleep_off: assert property (
		!enable [*4] |-> offBoth && fault_flag_n_oe_n) else $error("sleep");
	chk_follow_dir: assert property (
		!bridge_out_a_oe_n |-> bridge_out_a == $past(dir_in_a, 3)) else $error("dir");
	chk_bus_wait: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("wait");
endmodule
bind hbfp_top hbfp_top_chk i_hbfp_top_chk (.*);

// ==== dv/hbfp_host.sv ====
// host side: flag pull-up and disable pin driver
`timescale 1ns/10ps
module hbfp_host (
	// clock
	input wire logic clk,
	// open drain flag from the bridge
	input wire logic flagO,
	input wire logic flagOeN,
	// disable pins and flag level seen
	output logic disHi,
	output logic disLoN,
	output logic flagLvl
);
	// pull-up holds the line high unless pulled low
	assign flagLvl = flagOeN ? 1'b1 : flagO;
	initial {disHi, disLoN} = 2'b01;
	// set both disable pins, then let sync, latch release and output lag pass
	task automatic dis(input logic hi, input logic loN);
		@(posedge clk);
		disHi <= hi;
		disLoN <= loN;
		repeat (6) @(posedge clk);
	endtask
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench of the bridge protection block
`timescale 1ns/10ps
module tb_top;
	logic clk, rst_n, dir_in_a, dir_in_b, enable, short_detect, overtemp_detect;
	logic overtemp_below_hyst, undervolt_detect, current_limit_hit, avs_read, avs_write;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, r;
	logic bridge_out_a, bridge_out_a_oe_n, bridge_out_b, bridge_out_b_oe_n;
	logic fault_flag_n_o, fault_flag_n_oe_n, avs_waitrequest, irq, disHi, disLoN, flagLvl;
	int fails = 0;
	int n_compared = 0;
	logic [31:0] expQ[$];
	hbfp_top #(.TOFF_CYC(20)) i_hbfp_top (.*, .disable_hi_active(disHi),
		.disable_lo_active_n(disLoN));
	hbfp_host host (.clk, .flagO(fault_flag_n_o), .flagOeN(fault_flag_n_oe_n), .disHi,
		.disLoN, .flagLvl);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// count and report one compare
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask
	// one access, held until waitrequest drops
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge clk); while (avs_waitrequest);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// read, noting the expected word
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		expQ.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	// enables of both outputs and flag level
	task automatic pin(input logic [2:0] e);
		chk("pins", 32'({bridge_out_a_oe_n, bridge_out_b_oe_n, flagLvl}), 32'(e));
	endtask
	task automatic results();
		$display("compared %0d fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// oldest note against the read data
	always @(posedge clk) begin
		if (avs_read && !avs_waitrequest) begin
			chk("rdata", avs_readdata, expQ.pop_front());
		end
	end
	// watchdog
	initial begin
		w(20000);
		fails++;
		results();
	end
	initial begin
		{rst_n, dir_in_a, dir_in_b, short_detect, overtemp_detect, undervolt_detect} = '0;
		{current_limit_hit, avs_read, avs_write, avs_address, avs_writedata} = '0;
		{enable, overtemp_below_hyst} = 2'b11;
		r = $urandom(51464);
		w(16);
		rst_n <= 1'b1;
		w(4);
		rd(4'h0, 32'h1);
		rd(4'h3, 32'h0);
		bus(1'b1, 4'h9, 32'hffff_ffff);
		rd(4'h9, 32'h0);
		rd(4'h1, 32'h10);
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			@(posedge clk);
			dir_in_a <= r[0];
			dir_in_b <= r[1];
			w(4);
			chk("dir", 32'({bridge_out_b, bridge_out_a}), 32'(r[1:0]));
			pin(3'b001);
		end
		host.dis(1'b1, 1'b1);
		pin(3'b111);
		host.dis(1'b0, 1'b0);
		pin(3'b111);
		host.dis(1'b0, 1'b1);
		bus(1'b1, 4'h2, 32'h1f);
		bus(1'b1, 4'h3, 32'h1f);
		@(posedge clk) short_detect <= 1'b1;
		w(5);
		pin(3'b110);
		chk("irq", 32'(irq), 32'h1);
		@(posedge clk) dir_in_a <= !dir_in_a;
		w(4);
		pin(3'b110);
		// a current limit during the latch must not start a chop
		@(posedge clk) current_limit_hit <= 1'b1;
		w(4);
		rd(4'h1, 32'h1);
		@(posedge clk) current_limit_hit <= 1'b0;
		short_detect <= 1'b0;
		host.dis(1'b1, 1'b1);
		pin(3'b110);
		host.dis(1'b0, 1'b1);
		pin(3'b001);
		rd(4'h2, 32'h11);
		bus(1'b1, 4'h2, 32'h1f);
		w(2);
		chk("irq", 32'(irq), 32'h0);
		@(posedge clk) overtemp_below_hyst <= 1'b0;
		@(posedge clk) overtemp_detect <= 1'b1;
		w(5);
		pin(3'b110);
		@(posedge clk) overtemp_detect <= 1'b0;
		host.dis(1'b0, 1'b0);
		host.dis(1'b0, 1'b1);
		pin(3'b110);
		@(posedge clk) overtemp_below_hyst <= 1'b1;
		w(5);
		pin(3'b001);
		// off time of 20 clocks: outputs off from the fourth to the 24th edge
		@(posedge clk) current_limit_hit <= 1'b1;
		@(posedge clk) current_limit_hit <= 1'b0;
		w(12);
		chk("oe", 32'({bridge_out_a_oe_n, bridge_out_b_oe_n}), 32'h3);
		w(11);
		chk("oe", 32'({bridge_out_a_oe_n, bridge_out_b_oe_n}), 32'h3);
		w(1);
		pin(3'b001);
		// chop switched off: a limit hit leaves the outputs driven
		bus(1'b1, 4'h0, 32'h0);
		@(posedge clk) current_limit_hit <= 1'b1;
		@(posedge clk) current_limit_hit <= 1'b0;
		w(6);
		pin(3'b001);
		rd(4'h0, 32'h0);
		bus(1'b1, 4'h0, 32'h1);
		@(posedge clk) undervolt_detect <= 1'b1;
		w(5);
		pin(3'b110);
		@(posedge clk) undervolt_detect <= 1'b0;
		w(5);
		pin(3'b001);
		@(posedge clk) enable <= 1'b0;
		w(5);
		pin(3'b111);
		rd(4'h1, 32'h20);
		@(posedge clk) enable <= 1'b1;
		w(5);
		pin(3'b001);
		results();
	end
endmodule
